/* File: common/fpec_pkg.sv */
// types for the flash program/erase control block
package fpec_pkg;
  typedef enum logic [1:0] {
    FPEC_IDLE = 2'b00,
    FPEC_BUSY = 2'b01,
    FPEC_DONE = 2'b10
  } fpec_state_t;

  typedef enum logic [1:0] {
    FPEC_KEY_NONE = 2'b00,
    FPEC_KEY_HALF = 2'b01,
    FPEC_KEY_OPEN = 2'b10
  } fpec_key_t;

  typedef enum logic [3:0] {
    FPEC_ACT_NONE = 4'h0,
    FPEC_ACT_BOOT = 4'h1,
    FPEC_ACT_CHIP = 4'h2,
    FPEC_ACT_ROW4 = 4'h3,
    FPEC_ACT_ROW2 = 4'h4,
    FPEC_ACT_ROW1 = 4'h5,
    FPEC_ACT_CFG = 4'h6,
    FPEC_ACT_EEPROM = 4'h7,
    FPEC_ACT_GENERAL = 4'h8,
    FPEC_ACT_PROG = 4'h9
  } fpec_action_t;
endpackage

/* File: common/fpec_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH

// register addresses on the plain register port (word indices)
`define FPEC_ADDR_CONTROL 4'h0
`define FPEC_ADDR_KEY 4'h1
`define FPEC_ADDR_TBLPTR 4'h2
`define FPEC_ADDR_STATUS 4'h3

// control register field positions
`define FPEC_BIT_START 15
`define FPEC_BIT_ENABLE 14
`define FPEC_BIT_SEQERR 13
`define FPEC_BIT_PROGRAM_ONLY_SELECT 12
`define FPEC_BIT_ERASE 6
`define FPEC_OP_MSB 5
`define FPEC_CTRL_RESET 16'h0000
`define FPEC_CTRL_WMASK 16'h707f

// unlock key words
`define FPEC_KEY_FIRST 8'h55
`define FPEC_KEY_SECOND 8'haa

// self-timed operation lengths
`define FPEC_PROG_TIME_US 2
`define FPEC_ERASE_TIME_US 4
`define FPEC_CLK_MHZ 40
`define FPEC_PROG_CYCLES (`FPEC_PROG_TIME_US * `FPEC_CLK_MHZ)
`define FPEC_ERASE_CYCLES (`FPEC_ERASE_TIME_US * `FPEC_CLK_MHZ)

`endif

/* File: verification/fpec_ctrl_tb.sv */
// self-checking testbench for the flash program/erase control block
`timescale 1ns/1ps
`include "fpec_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module fpec_ctrl_tb;
  import fpec_pkg::*;
  // ***********************************
  // signals and design instance
  // ***********************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic serial_prog_mode = 1'b0;
  logic mem_busy;
  fpec_action_t mem_action;
  logic [15:0] mem_row_addr;
  logic mem_program_only;
  int err_total = 0;
  int checks = 0;
  // operation table: control fields, serial mode, action, program-only
  logic [15:0] fld [15] = '{16'h0068, 16'h0064, 16'h0068, 16'h0064,
    16'h005a, 16'h0059, 16'h0058, 16'h1058, 16'h0054, 16'h1050,
    16'h0050, 16'h004c, 16'h0004, 16'h1007, 16'h007f};
  logic [0:14] sm = 15'b110000000000000;
  logic [0:14] po = 15'b000000000100000;
  fpec_action_t act [15] = '{FPEC_ACT_BOOT, FPEC_ACT_CHIP, FPEC_ACT_NONE,
    FPEC_ACT_NONE, FPEC_ACT_ROW4, FPEC_ACT_ROW2, FPEC_ACT_ROW1,
    FPEC_ACT_ROW1, FPEC_ACT_CFG, FPEC_ACT_EEPROM, FPEC_ACT_EEPROM,
    FPEC_ACT_GENERAL, FPEC_ACT_PROG, FPEC_ACT_PROG, FPEC_ACT_NONE};

  fpec_ctrl dut (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .serial_prog_mode(serial_prog_mode),
    .mem_busy(mem_busy),
    .mem_action(mem_action),
    .mem_row_addr(mem_row_addr),
    .mem_program_only(mem_program_only)
  );

  // 40 mhz clock
  always #12.5 clk = ~clk;

  // ***********************************
  // register bus tasks
  // ***********************************
  // one idle cycle between strobes keeps each signal to one update per step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic complete_run;
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  // reset values, then unimplemented bits stay zero
  task automatic t_reset_bits;
    logic [15:0] d;
    rd(`FPEC_ADDR_CONTROL, d);
    `CHK(d, 16'h0000)
    wr(`FPEC_ADDR_CONTROL, 16'h7fff);
    rd(`FPEC_ADDR_CONTROL, d);
    `CHK(d, 16'h707f)
    wr(`FPEC_ADDR_CONTROL, 16'h0000);
  endtask

  // a start that must be refused: no run, error flag raised
  task automatic t_refused(input logic en, input logic split_key);
    logic [15:0] d;
    wr(`FPEC_ADDR_CONTROL, {1'b0, en, 14'h0});
    wr(`FPEC_ADDR_KEY, 16'h0055);
    if (split_key) begin
      wr(`FPEC_ADDR_TBLPTR, 16'h1234);
    end
    wr(`FPEC_ADDR_KEY, 16'h00aa);
    wr(`FPEC_ADDR_CONTROL, {1'b1, en, 14'h0});
    #1 `CHK(mem_busy, 1'b0)
    rd(`FPEC_ADDR_CONTROL, d);
    `CHK(d, {1'b0, en, 14'h2000})
  endtask

  // full launch: unlock, start, check outputs, poll until hardware clears
  task automatic t_run(input int i);
    logic [15:0] d;
    int n;
    serial_prog_mode <= sm[i];
    wr(`FPEC_ADDR_TBLPTR, 16'h0a00 + 16'(i));
    wr(`FPEC_ADDR_CONTROL, 16'h4000 | fld[i]);
    wr(`FPEC_ADDR_KEY, 16'h0055);
    wr(`FPEC_ADDR_KEY, 16'h00aa);
    wr(`FPEC_ADDR_CONTROL, 16'hc000 | fld[i]);
    #1 `CHK(mem_busy, 1'b1)
    `CHK(mem_action, act[i])
    `CHK(mem_row_addr, 16'h0a00 + 16'(i))
    `CHK(mem_program_only, po[i])
    @(posedge clk);
    rd(`FPEC_ADDR_STATUS, d);
    `CHK(d, {10'h000, act[i], 2'b01})
    // a zero written to the start bit must not stop the run
    wr(`FPEC_ADDR_CONTROL, 16'h4000);
    #1 `CHK(mem_busy, 1'b1)
    n = 0;
    d = 16'h8000;
    while (d[15] !== 1'b0 && n < 400) begin
      rd(`FPEC_ADDR_CONTROL, d);
      n++;
    end
    `CHK(d[15], 1'b0)
    `CHK(d[13], 1'b0)
    `CHK(mem_busy, 1'b0)
  endtask

  // ***********************************
  // main sequence and watchdog
  // ***********************************
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset_bits();
    t_refused(1'b1, 1'b1);
    t_refused(1'b0, 1'b0);
    for (int i = 0; i < 15; i++) begin
      t_run(i);
    end
    // a second start with no fresh key after a good run
    wr(`FPEC_ADDR_CONTROL, 16'hc004);
    #1 `CHK(mem_busy, 1'b0)
    complete_run();
  end

  // the whole table takes well under 20000 cycles
  initial begin
    #1500000;
    err_total++;
    complete_run();
  end
endmodule // fpec_ctrl_tb

/* File: verilog/fpec_ctrl.sv */
// flash program/erase control: registers, unlock, sequencer
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "fpec_regs.svh"
module fpec_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // device mode
  input wire logic serial_prog_mode,
  // memory array side
  output logic mem_busy,
  output fpec_pkg::fpec_action_t mem_action,
  output logic [15:0] mem_row_addr,
  output logic mem_program_only
);
  import fpec_pkg::*;

  // ********************************************************
  // register state
  // ********************************************************
  logic start_q;
  logic enable_q;
  logic seqerr_q;
  logic program_only_select_q;
  logic erase_q;
  logic [5:0] opcode_q;
  logic [15:0] tblptr_q;
  logic [15:0] rdata_q;
  logic [15:0] row_q;
  logic pgm_q;
  fpec_state_t state_q;
  fpec_state_t state_d;
  fpec_key_t key_q;
  fpec_key_t key_d;
  fpec_action_t act_q;

  // ********************************************************
  // address decode
  // ********************************************************
  wire wr_ctrl = reg_wr && (reg_addr == `FPEC_ADDR_CONTROL);
  wire wr_key = reg_wr && (reg_addr == `FPEC_ADDR_KEY);
  wire wr_tbl = reg_wr && (reg_addr == `FPEC_ADDR_TBLPTR);
  wire busy = (state_q == FPEC_BUSY);
  wire start_req = wr_ctrl && reg_wdata[`FPEC_BIT_START];

  // ********************************************************
  // operation decode
  // ********************************************************
  fpec_action_t act_dec;
  wire boot_code = (opcode_q[5:2] == 4'b1010);
  wire chip_code = (opcode_q[5:2] == 4'b1001);
  // operation code and erase select are taken as they stand at start
  always_comb begin
    act_dec = FPEC_ACT_NONE;
    if (erase_q) begin
      if (boot_code && serial_prog_mode) act_dec = FPEC_ACT_BOOT;
      else if (chip_code && serial_prog_mode) act_dec = FPEC_ACT_CHIP;
      else if (opcode_q == 6'h1a) act_dec = FPEC_ACT_ROW4;
      else if (opcode_q == 6'h19) act_dec = FPEC_ACT_ROW2;
      else if (opcode_q == 6'h18) act_dec = FPEC_ACT_ROW1;
      else if (opcode_q[5:2] == 4'b0101) act_dec = FPEC_ACT_CFG;
      else if (opcode_q[5:2] == 4'b0100) act_dec = FPEC_ACT_EEPROM;
      else if (opcode_q[5:2] == 4'b0011) act_dec = FPEC_ACT_GENERAL;
    end else if (opcode_q[5:2] == 4'b0001) begin
      act_dec = FPEC_ACT_PROG;
    end
  end

  // a start is good only straight after the full key and with enable set;
  // it must also wait for idle, since a start taken in the done cycle would
  // set the start bit while the sequencer falls back to idle and never ends
  wire start_ok = start_req && (state_q == FPEC_IDLE) &&
    (key_q == FPEC_KEY_OPEN) && enable_q;
  wire start_bad = start_req && !start_ok;
  wire op_len_erase = erase_q;

  // ********************************************************
  // self-timed sequencer
  // ********************************************************
  logic timer_load;
  logic timer_expired;
  logic [15:0] timer_cycles;
  assign timer_load = start_ok;
  assign timer_cycles = op_len_erase ? 16'(`FPEC_ERASE_CYCLES) :
    16'(`FPEC_PROG_CYCLES);

  fpec_op_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .load(timer_load),
    .cycles(timer_cycles),
    .expired(timer_expired)
  );

  // next state: idle, busy until the timer runs out, one done cycle
  always_comb begin
    case (state_q)
      FPEC_IDLE: state_d = start_ok ? FPEC_BUSY : FPEC_IDLE;
      FPEC_BUSY: state_d = timer_expired ? FPEC_DONE : FPEC_BUSY;
      FPEC_DONE: state_d = FPEC_IDLE;
      default: state_d = FPEC_IDLE;
    endcase
  end

  // ********************************************************
  // unlock key tracking
  // ********************************************************
  // any other register write breaks the sequence, so the start must
  // follow the second key word directly
  always_comb begin
    key_d = FPEC_KEY_NONE;
    if (wr_key && reg_wdata[7:0] == `FPEC_KEY_FIRST) begin
      key_d = FPEC_KEY_HALF;
    end else if (wr_key && reg_wdata[7:0] == `FPEC_KEY_SECOND &&
                 key_q == FPEC_KEY_HALF) begin
      key_d = FPEC_KEY_OPEN;
    end else if (!reg_wr) begin
      key_d = key_q; // reads and idle cycles keep the key state
    end
  end

  // ********************************************************
  // state, key and sequencer registers
  // ********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= FPEC_IDLE;
      key_q <= FPEC_KEY_NONE;
      act_q <= FPEC_ACT_NONE;
      row_q <= 16'h0000;
      pgm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      key_q <= key_d;
      if (start_ok) begin
        act_q <= act_dec;
        row_q <= tblptr_q;
        pgm_q <= program_only_select_q && (act_dec == FPEC_ACT_EEPROM);
      end else if (state_q == FPEC_DONE) begin
        act_q <= FPEC_ACT_NONE;
        pgm_q <= 1'b0; // program-only must not outlive its erase
      end
    end
  end

  // ********************************************************
  // control register
  // ********************************************************
  // start bit: set only by a good start, cleared only by hardware
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= 1'b0;
      seqerr_q <= 1'b0;
    end else begin
      if (start_ok) start_q <= 1'b1;
      else if (state_q == FPEC_DONE) start_q <= 1'b0;
      // hardware set wins over software clear in the same cycle
      if (start_bad) seqerr_q <= 1'b1;
      else if (start_ok) seqerr_q <= 1'b0;
      else if (wr_ctrl) seqerr_q <= reg_wdata[`FPEC_BIT_SEQERR];
    end
  end

  // plain fields; frozen while busy so the running operation is stable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= 1'b0;
      program_only_select_q <= 1'b0;
      erase_q <= 1'b0;
      opcode_q <= 6'h00;
      tblptr_q <= 16'h0000;
    end else begin
      if (wr_ctrl && !busy) begin
        enable_q <= reg_wdata[`FPEC_BIT_ENABLE];
        program_only_select_q <= reg_wdata[`FPEC_BIT_PROGRAM_ONLY_SELECT];
        erase_q <= reg_wdata[`FPEC_BIT_ERASE];
        opcode_q <= reg_wdata[`FPEC_OP_MSB:0];
      end
      if (wr_tbl && !busy) tblptr_q <= reg_wdata;
    end
  end

  // ********************************************************
  // read path
  // ********************************************************
  wire [15:0] ctrl_view = {start_q, enable_q, seqerr_q, program_only_select_q,
    5'b00000, erase_q, opcode_q};
  wire [15:0] status_view = {10'h000, act_q, state_q};
  wire [15:0] rd_mux =
    (reg_addr == `FPEC_ADDR_CONTROL) ? ctrl_view :
    (reg_addr == `FPEC_ADDR_TBLPTR) ? tblptr_q :
    (reg_addr == `FPEC_ADDR_STATUS) ? status_view : 16'h0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign mem_busy = start_q;
  assign mem_action = act_q;
  assign mem_row_addr = row_q;
  assign mem_program_only = pgm_q;

  // ********************************************************
  // assertions
  // ********************************************************
  // start bit and the self-timed run
  a_start_clears: assert property (@(posedge clk)
    disable iff (!rstn) start_ok |-> ##[1:170] !start_q)
    else $error("start bit not cleared after operation");
  a_good_start_runs: assert property (@(posedge clk)
    disable iff (!rstn) start_ok |=> start_q && state_q == FPEC_BUSY)
    else $error("good start did not launch a run");
  a_busy_has_run: assert property (@(posedge clk)
    disable iff (!rstn) start_q |-> state_q != FPEC_IDLE)
    else $error("start bit high with sequencer idle");
  // run lengths count from the accepting edge, plus the one done cycle
  a_prog_length: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && !erase_q |-> ##81 start_q ##1 !start_q)
    else $error("program run length wrong");
  a_erase_length: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q |-> ##161 start_q ##1 !start_q)
    else $error("erase run length wrong");
  a_idle_quiet: assert property (@(posedge clk)
    disable iff (!rstn) state_q == FPEC_IDLE |->
    mem_action == FPEC_ACT_NONE && !mem_program_only)
    else $error("memory action shown while idle");
  a_zero_write_kept: assert property (@(posedge clk)
    disable iff (!rstn) start_q && wr_ctrl && !reg_wdata[15] &&
    state_q == FPEC_BUSY |=> start_q)
    else $error("start bit cleared by software");
  a_start_set_only: assert property (@(posedge clk)
    disable iff (!rstn) !start_q && !start_ok |=> !start_q)
    else $error("start bit set without a good start");

  // gating and the sequence error flag
  a_enable_gates: assert property (@(posedge clk)
    disable iff (!rstn) start_req && !enable_q |=> !start_q)
    else $error("operation started while disabled");
  a_bad_start_err: assert property (@(posedge clk)
    disable iff (!rstn) start_bad |=> seqerr_q)
    else $error("bad start left error flag clear");
  a_good_clears_err: assert property (@(posedge clk)
    disable iff (!rstn) start_ok |=> !seqerr_q)
    else $error("good start left error flag set");
  a_err_holds: assert property (@(posedge clk)
    disable iff (!rstn) seqerr_q && !start_ok && !wr_ctrl |=> seqerr_q)
    else $error("error flag dropped on its own");
  a_unlock_needed: assert property (@(posedge clk)
    disable iff (!rstn) $rose(start_q) |-> $past(key_q) == FPEC_KEY_OPEN)
    else $error("start without unlock");

  // operation decode, checked against the codes themselves
  a_erase_select: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q |=> act_q != FPEC_ACT_PROG)
    else $error("program run with erase selected");
  a_fields_frozen: assert property (@(posedge clk)
    disable iff (!rstn) busy && wr_ctrl |=> erase_q == $past(erase_q) &&
    opcode_q == $past(opcode_q))
    else $error("operation fields changed during a run");
  a_boot_gated: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && !serial_prog_mode |=>
    act_q != FPEC_ACT_BOOT && act_q != FPEC_ACT_CHIP)
    else $error("boot or chip erase outside serial mode");
  a_boot_serial: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && serial_prog_mode &&
    opcode_q[5:2] == 4'b1010 |=> act_q == FPEC_ACT_BOOT)
    else $error("boot erase not selected in serial mode");
  a_chip_serial: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && serial_prog_mode &&
    opcode_q[5:2] == 4'b1001 |=> act_q == FPEC_ACT_CHIP)
    else $error("chip erase not selected in serial mode");
  a_four_rows: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && opcode_q == 6'h1a |=>
    act_q == FPEC_ACT_ROW4)
    else $error("four-row erase not selected");
  a_two_rows: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && opcode_q == 6'h19 |=>
    act_q == FPEC_ACT_ROW2)
    else $error("two-row erase not selected");
  a_one_row: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && opcode_q == 6'h18 |=>
    act_q == FPEC_ACT_ROW1)
    else $error("one-row erase not selected");
  a_cfg_erase: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && opcode_q[5:2] == 4'b0101
    |=> act_q == FPEC_ACT_CFG)
    else $error("config block erase not selected");
  a_eeprom_erase: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && opcode_q[5:2] == 4'b0100
    |=> act_q == FPEC_ACT_EEPROM)
    else $error("data eeprom erase not selected");
  a_general_erase: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && erase_q && opcode_q[5:2] == 4'b0011
    |=> act_q == FPEC_ACT_GENERAL)
    else $error("general block erase not selected");
  a_program_row: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && !erase_q && opcode_q[5:2] == 4'b0001
    |=> act_q == FPEC_ACT_PROG)
    else $error("row program not selected");
  a_undef_none: assert property (@(posedge clk)
    disable iff (!rstn) start_ok && !erase_q && opcode_q[5:2] != 4'b0001
    |=> act_q == FPEC_ACT_NONE)
    else $error("undefined program code caused an action");

  // memory side and read path
  a_row_from_ptr: assert property (@(posedge clk)
    disable iff (!rstn) start_ok |=> mem_row_addr == $past(tblptr_q))
    else $error("row address not from table pointer");
  a_pgm_flash_off: assert property (@(posedge clk)
    disable iff (!rstn) mem_program_only |-> act_q == FPEC_ACT_EEPROM)
    else $error("program-only asserted for flash");
  a_gap_bits_zero: assert property (@(posedge clk)
    disable iff (!rstn) $past(reg_rd) &&
    $past(reg_addr) == `FPEC_ADDR_CONTROL |-> reg_rdata[11:7] == 5'b00000)
    else $error("unimplemented bits read nonzero");

  // main scenarios
  c_good_run: cover property (@(posedge clk) disable iff (!rstn)
    start_ok ##[1:170] state_q == FPEC_DONE);
  c_bad_start: cover property (@(posedge clk) disable iff (!rstn)
    start_bad);
  c_erase_rows: cover property (@(posedge clk) disable iff (!rstn)
    start_ok && act_dec == FPEC_ACT_ROW4);
  c_boot_serial: cover property (@(posedge clk) disable iff (!rstn)
    start_ok && act_dec == FPEC_ACT_BOOT);
  c_eeprom_pgm: cover property (@(posedge clk) disable iff (!rstn)
    start_ok && act_dec == FPEC_ACT_EEPROM && program_only_select_q);
endmodule // fpec_ctrl

/* File: verilog/fpec_op_timer.sv */
// down-counter that times one self-timed memory operation
`timescale 1ns/1ps
module fpec_op_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic load,
  input wire logic [15:0] cycles,
  // status
  output logic expired
);
  logic [15:0] count_q;
  logic [15:0] count_d;

  // load wins over counting; a zero count holds
  assign count_d = load ? cycles :
    (count_q != 16'h0000) ? count_q - 16'h0001 : count_q;
  assign expired = (count_q == 16'h0001);

  // counter register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // fpec_op_timer
